/* File: pcu_defines.vh */
// Purpose: constants for the scan instruction datapath
// Assumes: included by pcu_exec_unit.v and by the bench
// Notes: register map uses word addresses on a 6-bit port
`ifndef PCU_DEFINES_VH
`define PCU_DEFINES_VH
// ****************************************
// Register word addresses
// ****************************************
`define PCU_A_CMD 6'h00
`define PCU_A_OPA 6'h01
`define PCU_A_OPB 6'h02
`define PCU_A_RESULT 6'h03
`define PCU_A_FLAGS 6'h04
`define PCU_A_FAST_PRESET 6'h05
`define PCU_A_FAST_COUNT 6'h06
`define PCU_A_REV_COUNT 6'h07
`define PCU_A_TABLE_LEN 6'h08
`define PCU_A_BLOCK_BASE 6'h09
`define PCU_A_RANGE_WORD 6'h0a
`define PCU_A_SHIFT 6'h0b
`define PCU_A_TIMER_SEL 6'h0c
`define PCU_A_TIMER1 6'h0d
`define PCU_A_TIMER2 6'h0e
`define PCU_A_TABLE_BASE 6'h20
`define PCU_A_TABLE_LAST 6'h33
// ****************************************
// Command codes
// ****************************************
`define PCU_OP_COPY 4'h1
`define PCU_OP_INV 4'h2
`define PCU_OP_CMP 4'h3
`define PCU_OP_ADD 4'h4
`define PCU_OP_SUB 4'h5
`define PCU_OP_AND 4'h6
`define PCU_OP_OR 4'h7
`define PCU_OP_CLC 4'h8
`define PCU_OP_RCMP 4'h9
// ****************************************
// Flag bit positions
// ****************************************
`define PCU_F_EQ 0
`define PCU_F_LT 1
`define PCU_F_GT 2
`define PCU_F_CY 3
// ****************************************
// Sizes, codes and timing
// ****************************************
`define PCU_RANGES 10
`define PCU_MAX_N 4'h9
`define PCU_BCD_ONE 16'h0001
`define PCU_BCD_NINES 16'h9999
`define PCU_SEL_1S 2'h0
`define PCU_SEL_100MS 2'h1
`define PCU_SEL_10MS 2'h2
`define PCU_UNITS_1S 7'h64
`define PCU_UNITS_100MS 7'h0a
`define PCU_UNITS_10MS 7'h01
`define PCU_CLK_MHZ 100
`define PCU_TICK_MS 10
`endif

/* File: pcu_exec_unit.v */
// Purpose: scan instruction datapath: counters, knob timers, moves, compares, BCD math
// Assumes: all pins synchronous to mclk_in; scan_end_in pulses once per program scan
// Notes: commands are started by writing the command register
// Behaviour
// - Fast counter adds one per pulse rise
// - Fast counter counts only gated, not reset
// - Completion flag on for exactly one scan
// - Fast count clears when preset reached
// - Preset 0000-9999; 0000 means 10,000
// - Range counter sets bits of matching ranges
// - Knob timers decrement, selector picks range
// - Knob timer preset only from knob
// - Copy writes source; zero sets equals
// - Inverted copy writes complement; zero sets equals
// - Compare sets exactly one relation flag
// - Shift register shifts on shift clock rise
// - Shift register cleared while reset on
// - Range compare uses N+1 ranges
// - Range pairs: lower then upper limit
// - Range compare sets bits of containing ranges
// - BCD add with carry in and out
// - BCD subtract with borrow in and out
// - Bitwise AND into result word
// - Bitwise OR into result word
// - Carry clear forces carry to zero
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "pcu_defines.vh"
module pcu_exec_unit #(
  parameter TICK_CYCLES = `PCU_TICK_MS * `PCU_CLK_MHZ * 1000
) (
  input wire mclk_in,
  input wire rst_in,
  input wire [5:0] addr_in,
  input wire [15:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [15:0] rdata_out,
  input wire scan_end_in,
  input wire count_pulse_input_in,
  input wire fast_gate_in,
  input wire fast_reset_in,
  input wire rev_up_in,
  input wire rev_down_in,
  input wire rev_reset_in,
  input wire shift_clock_input_in,
  input wire shift_data_in,
  input wire shift_reset_in,
  input wire [7:0] knob_one_in,
  input wire [7:0] knob_two_in,
  input wire [1:0] timer_run_in,
  output reg fast_done_out,
  output reg [1:0] timer_done_out,
  output reg [15:0] shift_word_out,
  output reg [15:0] range_word_out
);
  // ****************************************
  // BCD, range-count and timer-unit helpers
  // ****************************************
  // Four packed digits, decimal carry between them
  function [16:0] bcd_add;
    input [15:0] a;
    input [15:0] b;
    input ci;
    integer i;
    reg [4:0] s;
    reg c;
    begin
      c = ci;
      bcd_add = 17'h00000;
      for (i = 0; i < 4; i = i + 1) begin
        s = {1'b0, a[i*4 +: 4]} + {1'b0, b[i*4 +: 4]} + {4'h0, c};
        c = (s > 5'h09);
        s = c ? s + 5'h06 : s;
        bcd_add[i*4 +: 4] = s[3:0];
      end
      bcd_add[16] = c;
    end
  endfunction

  function [16:0] bcd_sub;
    input [15:0] a;
    input [15:0] b;
    input bi;
    reg [16:0] r;
    begin
      r = bcd_add(a, `PCU_BCD_NINES - b, ~bi); // Nines complement; carry means no borrow
      bcd_sub = {~r[16], r[15:0]};
    end
  endfunction

  // Limits a range count so it never walks past the table
  function [3:0] clamp_n;
    input [3:0] n;
    begin
      clamp_n = (n > `PCU_MAX_N) ? `PCU_MAX_N : n;
    end
  endfunction

  // Base ticks per timer unit; the unused code 3 runs as the 0.1 s range
  function [6:0] sel_units;
    input [1:0] sel;
    begin
      case (sel)
        `PCU_SEL_1S: sel_units = `PCU_UNITS_1S;
        `PCU_SEL_10MS: sel_units = `PCU_UNITS_10MS;
        default: sel_units = `PCU_UNITS_100MS;
      endcase
    end
  endfunction

  // ****************************************
  // Storage
  // ****************************************
  reg [15:0] opa_q;
  reg [15:0] opb_q;
  reg [15:0] result_q;
  reg [3:0] flags_q;
  reg [3:0] cmd_q;
  reg cmd_go_q;
  reg [15:0] fast_preset_q;
  reg [15:0] fast_count_q;
  reg fast_pending_q;
  reg [15:0] rev_count_q;
  reg [15:0] table_len_q;
  reg [15:0] block_base_q;
  reg [3:0] timer_sel_q;
  reg [15:0] table_q [0:2*`PCU_RANGES-1];
  reg cp_prev_q;
  reg up_prev_q;
  reg dn_prev_q;
  reg sp_prev_q;
  reg [19:0] tick_cnt_q;
  reg tick_q;
  reg [7:0] tmr_val_q [0:1];
  reg [6:0] tmr_sub_q [0:1];

  wire wr_table = wr_in && (addr_in >= `PCU_A_TABLE_BASE) && (addr_in <= `PCU_A_TABLE_LAST);
  wire [5:0] table_idx = addr_in - `PCU_A_TABLE_BASE;
  wire [3:0] rev_ranges = clamp_n(table_len_q[3:0]);
  wire [3:0] cmp_n = clamp_n(block_base_q[3:0]);

  // ****************************************
  // Range evaluation
  // ****************************************
  // Both range users share one table; the counter reads it every cycle
  wire [`PCU_RANGES-1:0] rev_hit;
  wire [`PCU_RANGES-1:0] cmp_hit;
  genvar g;
  generate
    for (g = 0; g < `PCU_RANGES; g = g + 1) begin : g_range
      wire [15:0] lo = table_q[2*g];
      wire [15:0] hi = table_q[2*g+1];
      assign rev_hit[g] = (g < rev_ranges) && (rev_count_q >= lo) && (rev_count_q <= hi);
      assign cmp_hit[g] = (g <= cmp_n) && (opa_q >= lo) && (opa_q <= hi);
    end
  endgenerate

  // ****************************************
  // Register writes and table
  // ****************************************
  integer k;
  always @(posedge mclk_in) begin
    if (rst_in) begin
      opa_q <= 16'h0000;
      opb_q <= 16'h0000;
      cmd_q <= 4'h0;
      cmd_go_q <= 1'b0;
      fast_preset_q <= 16'h0000;
      table_len_q <= 16'h0000;
      block_base_q <= 16'h0000;
      timer_sel_q <= 4'h0;
      for (k = 0; k < 2*`PCU_RANGES; k = k + 1) begin
        table_q[k] <= 16'h0000;
      end
    end else begin
      cmd_go_q <= wr_in && (addr_in == `PCU_A_CMD);
      if (wr_in) begin
        case (addr_in)
          `PCU_A_CMD: cmd_q <= wdata_in[3:0];
          `PCU_A_OPA: opa_q <= wdata_in;
          `PCU_A_OPB: opb_q <= wdata_in;
          `PCU_A_FAST_PRESET: fast_preset_q <= wdata_in;
          `PCU_A_TABLE_LEN: table_len_q <= wdata_in;
          `PCU_A_BLOCK_BASE: block_base_q <= wdata_in;
          `PCU_A_TIMER_SEL: timer_sel_q <= wdata_in[3:0];
          default: ;
        endcase
      end
      if (wr_table) begin
        table_q[table_idx[4:0]] <= wdata_in;
      end
    end
  end

  // ****************************************
  // Command execution
  // ****************************************
  reg [15:0] ex_val;
  reg [16:0] ex_bcd;
  always @* begin
    ex_val = 16'h0000;
    ex_bcd = 17'h00000;
    case (cmd_q)
      `PCU_OP_COPY: ex_val = opa_q;
      `PCU_OP_INV: ex_val = ~opa_q;
      `PCU_OP_AND: ex_val = opa_q & opb_q;
      `PCU_OP_OR: ex_val = opa_q | opb_q;
      `PCU_OP_ADD: ex_bcd = bcd_add(opa_q, opb_q, flags_q[`PCU_F_CY]);
      `PCU_OP_SUB: ex_bcd = bcd_sub(opa_q, opb_q, flags_q[`PCU_F_CY]);
      `PCU_OP_RCMP: ex_val = {{(16-`PCU_RANGES){1'b0}}, cmp_hit};
      default: ex_val = 16'h0000;
    endcase
  end

  always @(posedge mclk_in) begin
    if (rst_in) begin
      result_q <= 16'h0000;
      flags_q <= 4'h0;
    end else if (cmd_go_q) begin
      case (cmd_q)
        `PCU_OP_COPY, `PCU_OP_INV: begin
          result_q <= ex_val;
          flags_q[`PCU_F_EQ] <= (ex_val == 16'h0000);
        end
        `PCU_OP_AND, `PCU_OP_OR, `PCU_OP_RCMP: begin
          result_q <= ex_val;
        end
        `PCU_OP_ADD, `PCU_OP_SUB: begin
          result_q <= ex_bcd[15:0];
          flags_q[`PCU_F_CY] <= ex_bcd[16];
        end
        `PCU_OP_CMP: begin
          flags_q[`PCU_F_EQ] <= (opa_q == opb_q);
          flags_q[`PCU_F_LT] <= (opa_q < opb_q);
          flags_q[`PCU_F_GT] <= (opa_q > opb_q);
        end
        `PCU_OP_CLC: flags_q[`PCU_F_CY] <= 1'b0;
        default: ;
      endcase
    end
  end

  // ****************************************
  // Fast up counter
  // ****************************************
  // Count held in BCD so a zero preset falls out as the 9999 wrap
  wire [16:0] fast_next = bcd_add(fast_count_q, `PCU_BCD_ONE, 1'b0);
  wire fast_rise = count_pulse_input_in && !cp_prev_q;
  wire fast_ok = fast_gate_in && !fast_reset_in;
  wire fast_hit = (fast_preset_q == 16'h0000) ? fast_next[16] :
                  (fast_next[15:0] == fast_preset_q);
  always @(posedge mclk_in) begin
    if (rst_in) begin
      cp_prev_q <= 1'b0;
      fast_count_q <= 16'h0000;
      fast_pending_q <= 1'b0;
      fast_done_out <= 1'b0;
    end else begin
      cp_prev_q <= count_pulse_input_in;
      if (fast_reset_in) begin
        fast_count_q <= 16'h0000;
      end else if (fast_rise && fast_ok) begin
        fast_count_q <= fast_hit ? 16'h0000 : fast_next[15:0];
      end
      // A hit in the boundary cycle still reaches the next scan
      if (scan_end_in) begin
        fast_done_out <= fast_pending_q || (fast_rise && fast_ok && fast_hit);
        fast_pending_q <= 1'b0;
      end else if (fast_rise && fast_ok && fast_hit) begin
        fast_pending_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // Reversible range counter
  // ****************************************
  wire [16:0] rev_inc = bcd_add(rev_count_q, `PCU_BCD_ONE, 1'b0);
  wire [16:0] rev_dec = bcd_sub(rev_count_q, `PCU_BCD_ONE, 1'b0);
  wire up_rise = rev_up_in && !up_prev_q;
  wire dn_rise = rev_down_in && !dn_prev_q;
  always @(posedge mclk_in) begin
    if (rst_in) begin
      up_prev_q <= 1'b0;
      dn_prev_q <= 1'b0;
      rev_count_q <= 16'h0000;
      range_word_out <= 16'h0000;
    end else begin
      up_prev_q <= rev_up_in;
      dn_prev_q <= rev_down_in;
      if (rev_reset_in) begin
        rev_count_q <= 16'h0000;
      end else if (up_rise && !dn_rise) begin
        rev_count_q <= rev_inc[15:0];
      end else if (dn_rise && !up_rise) begin
        rev_count_q <= rev_dec[15:0];
      end
      range_word_out <= {{(16-`PCU_RANGES){1'b0}}, rev_hit};
    end
  end

  // ****************************************
  // Bit shift register
  // ****************************************
  always @(posedge mclk_in) begin
    if (rst_in) begin
      sp_prev_q <= 1'b0;
      shift_word_out <= 16'h0000;
    end else begin
      sp_prev_q <= shift_clock_input_in;
      if (shift_reset_in) begin
        shift_word_out <= 16'h0000;
      end else if (shift_clock_input_in && !sp_prev_q) begin
        shift_word_out <= {shift_word_out[14:0], shift_data_in};
      end
    end
  end

  // ****************************************
  // Knob timers
  // ****************************************
  // Shared 10 ms base; finer ranges just take fewer base ticks per unit
  always @(posedge mclk_in) begin
    if (rst_in) begin
      tick_cnt_q <= 20'h00000;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == TICK_CYCLES - 1) begin
      tick_cnt_q <= 20'h00000;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 20'h00001;
      tick_q <= 1'b0;
    end
  end

  // One process owns both timers so every timer flop has a single driver
  integer m;
  always @(posedge mclk_in) begin
    for (m = 0; m < 2; m = m + 1) begin
      if (rst_in) begin
        tmr_val_q[m] <= 8'h00;
        tmr_sub_q[m] <= 7'h00;
        timer_done_out[m] <= 1'b0;
      end else if (!timer_run_in[m]) begin
        tmr_val_q[m] <= (m == 0) ? knob_one_in : knob_two_in;
        tmr_sub_q[m] <= sel_units(timer_sel_q[2*m +: 2]);
        timer_done_out[m] <= 1'b0;
      end else if (tmr_val_q[m] == 8'h00) begin
        timer_done_out[m] <= 1'b1;
      end else if (tick_q) begin
        if (tmr_sub_q[m] == 7'h01) begin
          tmr_sub_q[m] <= sel_units(timer_sel_q[2*m +: 2]);
          tmr_val_q[m] <= tmr_val_q[m] - 8'h01;
        end else begin
          tmr_sub_q[m] <= tmr_sub_q[m] - 7'h01;
        end
      end
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  reg [15:0] rd_mux;
  always @* begin
    rd_mux = 16'h0000;
    case (addr_in)
      `PCU_A_CMD: rd_mux = {12'h000, cmd_q};
      `PCU_A_OPA: rd_mux = opa_q;
      `PCU_A_OPB: rd_mux = opb_q;
      `PCU_A_RESULT: rd_mux = result_q;
      `PCU_A_FLAGS: rd_mux = {12'h000, flags_q};
      `PCU_A_FAST_PRESET: rd_mux = fast_preset_q;
      `PCU_A_FAST_COUNT: rd_mux = fast_count_q;
      `PCU_A_REV_COUNT: rd_mux = rev_count_q;
      `PCU_A_TABLE_LEN: rd_mux = table_len_q;
      `PCU_A_BLOCK_BASE: rd_mux = block_base_q;
      `PCU_A_RANGE_WORD: rd_mux = range_word_out;
      `PCU_A_SHIFT: rd_mux = shift_word_out;
      `PCU_A_TIMER_SEL: rd_mux = {12'h000, timer_sel_q};
      `PCU_A_TIMER1: rd_mux = {8'h00, tmr_val_q[0]};
      `PCU_A_TIMER2: rd_mux = {8'h00, tmr_val_q[1]};
      default: rd_mux = (addr_in >= `PCU_A_TABLE_BASE && addr_in <= `PCU_A_TABLE_LAST) ?
                        table_q[table_idx[4:0]] : 16'h0000;
    endcase
  end

  always @(posedge mclk_in) begin
    if (rst_in) begin
      rdata_out <= 16'h0000;
    end else begin
      rdata_out <= rd_in ? rd_mux : 16'h0000;
    end
  end
endmodule // pcu_exec_unit

/* File: pcu_exec_unit_assertions.sv */
// Purpose: port-level checks for the scan instruction datapath
// Assumes: one clock, synchronous active-high reset
// Notes: register contents are judged by the bench over the bus
`timescale 1ns/1ps
module pcu_exec_unit_assertions #(
  parameter TICK_CYCLES = 1000000
) (
  input wire mclk_in,
  input wire rst_in,
  input wire scan_end_in,
  input wire fast_done_out,
  input wire shift_clock_input_in,
  input wire shift_data_in,
  input wire shift_reset_in,
  input wire [15:0] shift_word_out,
  input wire [15:0] range_word_out,
  input wire [1:0] timer_run_in,
  input wire [1:0] timer_done_out,
  input wire wr_in,
  input wire rev_up_in,
  input wire rev_down_in,
  input wire rev_reset_in
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  // Done may only move at a scan boundary, so it spans whole scans
  property p_done_rise; $rose(fast_done_out) |-> $past(scan_end_in); endproperty
  a_done_rise: assert property (p_done_rise) else $error("done rose off scan end");
  property p_done_hold; fast_done_out && !scan_end_in |=> fast_done_out; endproperty
  a_done_hold: assert property (p_done_hold) else $error("done dropped mid scan");
  property p_shift_clear; shift_reset_in |=> shift_word_out == 16'h0000; endproperty
  a_shift_clear: assert property (p_shift_clear) else $error("shift not cleared");
  property p_shift_move;
    $rose(shift_clock_input_in) && !shift_reset_in |=>
      shift_word_out == {$past(shift_word_out[14:0]), $past(shift_data_in)};
  endproperty
  a_shift_move: assert property (p_shift_move) else $error("shift step wrong");
  property p_shift_hold;
    !$rose(shift_clock_input_in) && !shift_reset_in |=> $stable(shift_word_out);
  endproperty
  a_shift_hold: assert property (p_shift_hold) else $error("shift moved");
  property p_range_top; range_word_out[15:10] == 6'h00; endproperty
  a_range_top: assert property (p_range_top) else $error("range bit over 9");
  // The range word only follows a count step, a clear or a table write
  property p_range_move;
    $changed(range_word_out) |-> $past(rev_up_in, 2) || $past(rev_down_in, 2) ||
      $past(rev_reset_in, 2) || $past(wr_in, 2);
  endproperty
  a_range_move: assert property (p_range_move) else $error("range word moved alone");
  property p_timer_load; ##1 (timer_done_out & ~$past(timer_run_in)) == 2'h0; endproperty
  a_timer_load: assert property (p_timer_load) else $error("done while loading");
  // Knob value is at least one unit, so done cannot follow the start at once
  property p_timer_start; $rose(timer_run_in[0]) |=> !timer_done_out[0]; endproperty
  a_timer_start: assert property (p_timer_start) else $error("done at start");
  c_done: cover property ($rose(fast_done_out));
  c_shift: cover property ($rose(shift_clock_input_in) && !shift_reset_in);
  c_timer: cover property ($rose(timer_done_out[0]));
endmodule // pcu_exec_unit_assertions

bind pcu_exec_unit pcu_exec_unit_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .mclk_in(mclk_in), .rst_in(rst_in), .scan_end_in(scan_end_in),
  .fast_done_out(fast_done_out), .shift_clock_input_in(shift_clock_input_in),
  .shift_data_in(shift_data_in), .shift_reset_in(shift_reset_in),
  .shift_word_out(shift_word_out), .range_word_out(range_word_out),
  .timer_run_in(timer_run_in), .timer_done_out(timer_done_out), .wr_in(wr_in),
  .rev_up_in(rev_up_in), .rev_down_in(rev_down_in), .rev_reset_in(rev_reset_in)
);

/* File: pcu_exec_unit_tb.sv */
// Purpose: self-checking bench for the scan instruction datapath
// Assumes: tick shortened to 4 clocks to keep timer runs short
// Notes: inputs change by non-blocking assignment at rising edges
`timescale 1ns/1ps
`include "pcu_defines.vh"
module pcu_exec_unit_tb;
  localparam TK = 4;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [5:0] addr = 6'h00;
  reg [15:0] wd = 16'h0000;
  reg wr = 1'b0, rd = 1'b0, se = 1'b0, cp = 1'b0, gate = 1'b0, frst = 1'b0;
  reg up = 1'b0, dn = 1'b0, rrst = 1'b0, sck = 1'b0, sdat = 1'b0, srst = 1'b0;
  reg [1:0] run = 2'h0;
  wire [15:0] rdata, sword, rword;
  wire done;
  wire [1:0] tdone;
  int bad_count = 0;
  int num_checks = 0;
  int i, j, m, n, u, hi;
  logic [55:0] t [0:17];
  logic [15:0] rg [0:7];
  initial forever #5 clk = ~clk;
  pcu_exec_unit #(.TICK_CYCLES(TK)) u_dut (
    .mclk_in(clk), .rst_in(rst), .addr_in(addr), .wdata_in(wd), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .scan_end_in(se), .count_pulse_input_in(cp), .fast_gate_in(gate),
    .fast_reset_in(frst), .rev_up_in(up), .rev_down_in(dn), .rev_reset_in(rrst),
    .shift_clock_input_in(sck), .shift_data_in(sdat), .shift_reset_in(srst),
    .knob_one_in(8'h02), .knob_two_in(8'h05), .timer_run_in(run), .fast_done_out(done),
    .timer_done_out(tdone), .shift_word_out(sword), .range_word_out(rword)
  );
  // ****************************************
  // Bus and stimulus tasks
  // ****************************************
  task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wreg(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task rreg(input logic [5:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("register", rdata, e);
  endtask
  task fp(input int c);
    repeat (c) begin
      @(posedge clk);
      cp <= 1'b1;
      @(posedge clk);
      cp <= 1'b0;
    end
  endtask
  task rp(input int c, input logic u);
    repeat (c) begin
      @(posedge clk);
      up <= u;
      dn <= !u;
      @(posedge clk);
      up <= 1'b0;
      dn <= 1'b0;
    end
    repeat (2) @(posedge clk);
    #1;
  endtask
  task scan;
    @(posedge clk);
    se <= 1'b1;
    @(posedge clk);
    se <= 1'b0;
    #1;
  endtask
  task sh(input logic b);
    @(posedge clk);
    sck <= 1'b1;
    sdat <= b;
    @(posedge clk);
    sck <= 1'b0;
    #1;
  endtask
  task wrap_up;
    $display("Checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    // Entry: command, first operand, second operand, result, flags; dead and f skip
    t = '{
      {4'h1, 16'h1234, 16'h0000, 16'h1234, 4'h0}, {4'h1, 16'h0000, 16'h0000, 16'h0000, 4'h1},
      {4'h2, 16'hffff, 16'h0000, 16'h0000, 4'h1}, {4'h2, 16'h0000, 16'h0000, 16'hffff, 4'h0},
      {4'h3, 16'h0003, 16'h0005, 16'hdead, 4'h2}, {4'h3, 16'h0005, 16'h0003, 16'hdead, 4'h4},
      {4'h3, 16'h0007, 16'h0007, 16'hdead, 4'h1}, {4'h4, 16'h9999, 16'h0001, 16'h0000, 4'h9},
      {4'h5, 16'h0005, 16'h0002, 16'h0002, 4'h1}, {4'h5, 16'h0000, 16'h0001, 16'h9999, 4'h9},
      {4'h4, 16'h0001, 16'h0001, 16'h0003, 4'h1}, {4'h4, 16'h5000, 16'h5000, 16'h0000, 4'h9},
      {4'h8, 16'h0000, 16'h0000, 16'hdead, 4'h1},
      {4'h4, 16'h4321, 16'h5678, 16'h9999, 4'h1},
      {4'h6, 16'h0ff0, 16'h3c3c, 16'h0c30, 4'hf}, {4'h7, 16'h0ff0, 16'h3c3c, 16'h3ffc, 4'hf},
      {4'h9, 16'h0018, 16'h0000, 16'h0003, 4'hf}, {4'h9, 16'h0040, 16'h0000, 16'h0004, 4'hf}};
    // Last range covers everything but lies beyond N, so it must never show
    rg = '{16'h0010, 16'h0020, 16'h0015, 16'h0030, 16'h0040, 16'h0050, 16'h0000, 16'h9999};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 8; i++) wreg(6'(`PCU_A_TABLE_BASE + i), rg[i]);
    wreg(`PCU_A_BLOCK_BASE, 16'h0012);
    wreg(`PCU_A_TABLE_LEN, 16'h0003);
    for (i = 0; i < 18; i++) begin
      wreg(`PCU_A_OPA, t[i][51:36]);
      wreg(`PCU_A_OPB, t[i][35:20]);
      wreg(`PCU_A_CMD, {12'h000, t[i][55:52]});
      if (t[i][19:4] != 16'hdead) begin
        rreg(`PCU_A_RESULT, t[i][19:4]);
      end
      if (t[i][3:0] != 4'hf) begin
        rreg(`PCU_A_FLAGS, {12'h000, t[i][3:0]});
      end
    end
    $display("Test commands done");
    @(posedge clk) rrst <= 1'b1;
    @(posedge clk) rrst <= 1'b0;
    rp(16, 1'b1);
    chk("range word", rword, 16'h0003);
    rreg(`PCU_A_REV_COUNT, 16'h0016);
    rp(7, 1'b0);
    chk("range word", rword, 16'h0000);
    $display("Test range counter done");
    wreg(`PCU_A_FAST_PRESET, 16'h0003);
    @(posedge clk) gate <= 1'b1;
    fp(2);
    rreg(`PCU_A_FAST_COUNT, 16'h0002);
    @(posedge clk) gate <= 1'b0;
    fp(1);
    @(posedge clk) gate <= 1'b1;
    rreg(`PCU_A_FAST_COUNT, 16'h0002);
    @(posedge clk) frst <= 1'b1;
    fp(1);
    @(posedge clk) frst <= 1'b0;
    rreg(`PCU_A_FAST_COUNT, 16'h0000);
    fp(3);
    rreg(`PCU_A_FAST_COUNT, 16'h0000);
    chk("done", {15'h0, done}, 16'h0000);
    scan;
    chk("done", {15'h0, done}, 16'h0001);
    repeat (5) @(posedge clk);
    chk("done", {15'h0, done}, 16'h0001);
    scan;
    chk("done", {15'h0, done}, 16'h0000);
    wreg(`PCU_A_FAST_PRESET, 16'h0000);
    fp(9999);
    rreg(`PCU_A_FAST_COUNT, 16'h9999);
    fp(1);
    rreg(`PCU_A_FAST_COUNT, 16'h0000);
    scan;
    chk("done", {15'h0, done}, 16'h0001);
    $display("Test fast counter done");
    sh(1'b1);
    sh(1'b0);
    sh(1'b1);
    sh(1'b1);
    chk("shift word", sword, 16'h000b);
    rreg(`PCU_A_SHIFT, 16'h000b);
    @(posedge clk) srst <= 1'b1;
    sh(1'b1);
    chk("shift word", sword, 16'h0000);
    @(posedge clk) srst <= 1'b0;
    $display("Test shift register done");
    rreg(`PCU_A_TIMER2, 16'h0005);
    wreg(`PCU_A_TIMER2, 16'h0000);
    rreg(`PCU_A_TIMER2, 16'h0005);
    for (j = 0; j < 3; j++) begin
      wreg(`PCU_A_TIMER_SEL, 16'(j * 5));
      repeat (3) @(posedge clk);
      rreg(`PCU_A_TIMER1, 16'h0002);
      @(posedge clk) run <= 2'h3;
      u = (j == 0) ? 100 : (j == 1) ? 10 : 1;
      n = 0;
      for (m = 0; m < 2; m++) begin
        while (tdone[m] !== 1'b1 && n < 4000) begin
          @(posedge clk);
          #1;
          n++;
        end
        if (tdone[m] !== 1'b1) begin
          bad_count++;
          wrap_up;
        end
        // Both start together; the free-running tick may cut the first unit short
        hi = (m == 0 ? 2 : 5) * u * TK;
        chk("timer span", 16'(n > hi - u * TK - TK && n <= hi + 4), 16'h0001);
        if (m == 0) chk("timer two busy", {15'h0, tdone[1]}, 16'h0000);
      end
      @(posedge clk) run <= 2'h0;
    end
    $display("Test knob timers done");
    wrap_up;
  end
endmodule // pcu_exec_unit_tb
